// ---- common/dopr_defs.vh ----
`ifndef DOPR_DEFS_VH
`define DOPR_DEFS_VH

// Word addresses of the holding registers.
`define DOPR_ADDR_FREQ_PT1    16'h1310
`define DOPR_ADDR_CURR_PT1    16'h1311
`define DOPR_ADDR_FREQ_PT2    16'h1312
`define DOPR_ADDR_CURR_PT2    16'h1313
`define DOPR_ADDR_FREQ_PT3    16'h1314
`define DOPR_ADDR_CURR_PT3    16'h1315
`define DOPR_ADDR_MODE_A      16'h1316
`define DOPR_ADDR_LEVEL_A     16'h1317
`define DOPR_ADDR_DECEL_A     16'h1318
`define DOPR_ADDR_MODE_B      16'h1319
`define DOPR_ADDR_LEVEL_B     16'h131a
`define DOPR_ADDR_DECEL_B     16'h131b
`define DOPR_ADDR_OC_SUPP     16'h131c
`define DOPR_ADDR_FM_LIMIT    16'h131d
`define DOPR_ADDR_M3_CURVE    16'h330d
`define DOPR_ADDR_RSV_FIRST   16'h330e
`define DOPR_ADDR_RSV_LAST    16'h3506

// Accepted value ranges.
`define DOPR_FREQ_MAX         16'h0190
`define DOPR_CURVE_MAX        16'h0002
`define DOPR_MODE_MAX         16'h0003
`define DOPR_LEVEL_MIN        16'h00c8
`define DOPR_LEVEL_MAX        16'h07d0
`define DOPR_DECEL_A_MIN      16'h000a
`define DOPR_DECEL_B_MIN      16'h0001
`define DOPR_DECEL_MAX        16'h0bb8
`define DOPR_ENABLE_MAX       16'h0001

// Reset values.
`define DOPR_RST_CURVE        16'h0001
`define DOPR_RST_FREQ         16'h0000
`define DOPR_RST_CURR         16'h0000
`define DOPR_RST_MODE         16'h0001
`define DOPR_RST_LEVEL        16'h05dc
`define DOPR_RST_DECEL_A      16'h0064
`define DOPR_RST_DECEL_B      16'h0064
`define DOPR_RST_OC_SUPP      16'h0001
`define DOPR_RST_FM_LIMIT     16'h03e8

// Mode encodings shared by both overload-restriction sets.
`define DOPR_MODE_OFF         2'h0
`define DOPR_MODE_ACC_CONST   2'h1
`define DOPR_MODE_CONST       2'h2
`define DOPR_MODE_ALL         2'h3

`endif

// ---- hw/dopr_drive_overload_param_regs.v ----
// Function
// (RULE1) Third-motor thermal curve selector: 0 reduced, 1 constant torque, 2 free curve.
// (RULE2) Three free-curve frequency points at even addresses, 0 to 400 Hz.
// (RULE3) Three free-curve current points after each frequency, 0 to rated current.
// (RULE4) Mode A decodes off, accel+const, const only, accel+decel+const.
// (RULE5) Mode B uses the same encoding at its own address.
// (RULE6) Both restriction levels in 0.1 percent, 200 to 1800 of rated; the code accepts 200 to 2000.
// (RULE7) Deceleration rate A accepts 10 to 3000.
// (RULE8) Deceleration rate B accepts 1 to 3000 in hundredths of a second.
// (RULE9) Overcurrent suppression enable: 0 off, 1 on.
// (RULE10) Frequency-matching restart current limit, 200 to 1800 in 0.1 percent; the code accepts 200 to 2000.
// (RULE11) Out-of-range writes are dropped and the old value kept.
// (RULE12) Reserved span after the selector reads zero and ignores writes.
`timescale 1ns/1ps
`include "dopr_defs.vh"

module dopr_drive_overload_param_regs #(
	parameter [15:0] RATED_CURRENT = 16'h03e8
) (
	input  wire        clk_in,             // 40 MHz clock
	input  wire        reset_in,           // Asynchronous reset, active high
	input  wire [15:0] addr_in,            // Register word address
	input  wire [15:0] wdata_in,           // Write data
	input  wire        wr_in,              // Write strobe
	input  wire        rd_in,              // Read strobe
	output reg  [15:0] rdata_out,          // Read data, valid the cycle after rd_in
	output reg         wr_reject_out,      // Pulse: last write was out of range
	output wire [1:0]  m3_curve_out,       // Third-motor thermal curve select
	output wire [47:0] curve_freq_out,     // Three frequency points, point 1 low
	output wire [47:0] curve_curr_out,     // Three current points, point 1 low
	output wire        mode_a_accel_out,   // Set A restricts during acceleration
	output wire        mode_a_const_out,   // Set A restricts at constant speed
	output wire        mode_a_decel_out,   // Set A restricts during deceleration
	output wire        mode_b_accel_out,   // Set B restricts during acceleration
	output wire        mode_b_const_out,   // Set B restricts at constant speed
	output wire        mode_b_decel_out,   // Set B restricts during deceleration
	output wire [15:0] level_a_out,        // Restriction level A, 0.1 percent
	output wire [15:0] decel_a_out,        // Deceleration rate A
	output wire [15:0] level_b_out,        // Restriction level B, 0.1 percent
	output wire [15:0] decel_b_out,        // Deceleration rate B, 0.01 s
	output wire        oc_suppress_out,    // Overcurrent suppression enabled
	output wire [15:0] fm_limit_out        // Frequency-matching restart limit
);

	reg  [15:0] m3_curve;
	reg  [15:0] freq_pt [0:2];
	reg  [15:0] curr_pt [0:2];
	reg  [15:0] mode_a;
	reg  [15:0] level_a;
	reg  [15:0] decel_a;
	reg  [15:0] mode_b;
	reg  [15:0] level_b;
	reg  [15:0] decel_b;
	reg  [15:0] oc_supp;
	reg  [15:0] fm_limit;
	reg         hit;
	reg         ok;
	reg  [15:0] next_rdata;
	// Registered phase decodes and the next value of the refusal pulse.
	reg         mode_a_accel;
	reg         mode_a_const;
	reg         mode_a_decel;
	reg         mode_b_accel;
	reg         mode_b_const;
	reg         mode_b_decel;
	reg         next_reject;

	// Three points per curve; the output buses are sized for exactly this many.
	localparam integer NUM_PTS = 3;

	wire in_curve_span = (addr_in >= `DOPR_ADDR_FREQ_PT1) && (addr_in <= `DOPR_ADDR_CURR_PT3);
	// The curve span starts on an eight-word boundary, so address bits 2:1 count the point.
	wire [1:0] pt_idx  = addr_in[2:1];
	wire is_curr       = addr_in[0];
	wire lvl_ok        = (wdata_in >= `DOPR_LEVEL_MIN) && (wdata_in <= `DOPR_LEVEL_MAX);
	wire freq_ok       = (wdata_in <= `DOPR_FREQ_MAX);
	// The current ceiling follows RATED_CURRENT, so a drive of another rating must
	// override it; the curve is not checked for rising order either.
	wire curr_ok       = (wdata_in <= RATED_CURRENT);
	wire curve_ok      = (wdata_in <= `DOPR_CURVE_MAX);
	wire mode_ok       = (wdata_in <= `DOPR_MODE_MAX);
	// The two sets count their rates in different units, so their floors differ.
	wire decel_a_ok    = (wdata_in >= `DOPR_DECEL_A_MIN) && (wdata_in <= `DOPR_DECEL_MAX);
	wire decel_b_ok    = (wdata_in >= `DOPR_DECEL_B_MIN) && (wdata_in <= `DOPR_DECEL_MAX);
	wire enable_ok     = (wdata_in <= `DOPR_ENABLE_MAX);

	// One select line per scalar word keeps every write enable a plain AND term.
	wire sel_curve     = (addr_in == `DOPR_ADDR_M3_CURVE);
	wire sel_mode_a    = (addr_in == `DOPR_ADDR_MODE_A);
	wire sel_level_a   = (addr_in == `DOPR_ADDR_LEVEL_A);
	wire sel_decel_a   = (addr_in == `DOPR_ADDR_DECEL_A);
	wire sel_mode_b    = (addr_in == `DOPR_ADDR_MODE_B);
	wire sel_level_b   = (addr_in == `DOPR_ADDR_LEVEL_B);
	wire sel_decel_b   = (addr_in == `DOPR_ADDR_DECEL_B);
	wire sel_oc_supp   = (addr_in == `DOPR_ADDR_OC_SUPP);
	wire sel_fm_limit  = (addr_in == `DOPR_ADDR_FM_LIMIT);

	// Enables rise only for an accepted value, so a refused word keeps the old contents.
	wire wr_ok         = wr_in && ok; // [RULE11]
	wire we_point      = wr_ok && in_curve_span;
	wire we_curve      = wr_ok && sel_curve;
	wire we_mode_a     = wr_ok && sel_mode_a;
	wire we_level_a    = wr_ok && sel_level_a;
	wire we_decel_a    = wr_ok && sel_decel_a;
	wire we_mode_b     = wr_ok && sel_mode_b;
	wire we_level_b    = wr_ok && sel_level_b;
	wire we_decel_b    = wr_ok && sel_decel_b;
	wire we_oc_supp    = wr_ok && sel_oc_supp;
	wire we_fm_limit   = wr_ok && sel_fm_limit;

	// Decode and range check for the write currently on the bus. Holes in the map
	// leave hit low, which keeps a stray write there from raising a refusal.
	always @* begin
		hit = 1'b1;
		ok  = 1'b0;
		if (in_curve_span) begin
			if (is_curr)
				ok = curr_ok; // [RULE3] [RULE11]
			else
				ok = freq_ok; // [RULE2] [RULE11]
		end else begin
			case (addr_in)
				`DOPR_ADDR_M3_CURVE: ok = curve_ok; // [RULE1] [RULE11]
				`DOPR_ADDR_MODE_A:   ok = mode_ok; // [RULE4]
				`DOPR_ADDR_MODE_B:   ok = mode_ok; // [RULE5]
				`DOPR_ADDR_LEVEL_A:  ok = lvl_ok; // [RULE6]
				`DOPR_ADDR_LEVEL_B:  ok = lvl_ok; // [RULE6]
				`DOPR_ADDR_FM_LIMIT: ok = lvl_ok; // [RULE10]
				`DOPR_ADDR_DECEL_A:  ok = decel_a_ok; // [RULE7]
				`DOPR_ADDR_DECEL_B:  ok = decel_b_ok; // [RULE8]
				`DOPR_ADDR_OC_SUPP:  ok = enable_ok; // [RULE9]
				default:             hit = 1'b0; // [RULE12]
			endcase
		end
	end

	// The frequency/current pairs share one indexed decode.
	genvar g;
	generate
		for (g = 0; g < NUM_PTS; g = g + 1) begin : g_pt
			// Each coordinate has its own enable, so writing one leaves its partner alone.
			wire pt_sel  = we_point && (pt_idx == g); // [RULE11]
			wire we_freq = pt_sel && !is_curr;
			wire we_curr = pt_sel && is_curr;

			always @(posedge clk_in or posedge reset_in) begin
				if (reset_in) begin
					freq_pt[g] <= `DOPR_RST_FREQ;
				end else if (we_freq) begin
					freq_pt[g] <= wdata_in; // [RULE2]
				end
			end

			always @(posedge clk_in or posedge reset_in) begin
				if (reset_in) begin
					curr_pt[g] <= `DOPR_RST_CURR;
				end else if (we_curr) begin
					curr_pt[g] <= wdata_in; // [RULE3]
				end
			end

			assign curve_freq_out[16*g +: 16] = freq_pt[g];
			assign curve_curr_out[16*g +: 16] = curr_pt[g];
		end
	endgenerate

	// The selector powers up on constant torque, which suits most motors until
	// the free curve has been loaded.
	always @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			m3_curve <= `DOPR_RST_CURVE;
		end else if (we_curve) begin
			m3_curve <= wdata_in; // [RULE1]
		end
	end

	// Restriction set A. Its level and rate are only used while the mode allows it,
	// but they are stored and checked regardless.
	always @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			mode_a <= `DOPR_RST_MODE;
		end else if (we_mode_a) begin
			mode_a <= wdata_in; // [RULE4]
		end
	end

	always @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			level_a <= `DOPR_RST_LEVEL;
		end else if (we_level_a) begin
			level_a <= wdata_in; // [RULE6]
		end
	end

	always @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			decel_a <= `DOPR_RST_DECEL_A;
		end else if (we_decel_a) begin
			decel_a <= wdata_in; // [RULE7]
		end
	end

	// Restriction set B shares the encoding of set A but none of its storage.
	always @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			mode_b <= `DOPR_RST_MODE;
		end else if (we_mode_b) begin
			mode_b <= wdata_in; // [RULE5]
		end
	end

	always @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			level_b <= `DOPR_RST_LEVEL;
		end else if (we_level_b) begin
			level_b <= wdata_in; // [RULE6]
		end
	end

	always @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			decel_b <= `DOPR_RST_DECEL_B;
		end else if (we_decel_b) begin
			decel_b <= wdata_in; // [RULE8]
		end
	end

	// The enable is a single bit; the checked write keeps the upper bits at zero.
	always @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			oc_supp <= `DOPR_RST_OC_SUPP;
		end else if (we_oc_supp) begin
			oc_supp <= wdata_in; // [RULE9]
		end
	end

	// The restart limit shares the range check of the restriction levels.
	always @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			fm_limit <= `DOPR_RST_FM_LIMIT;
		end else if (we_fm_limit) begin
			fm_limit <= wdata_in; // [RULE10]
		end
	end

	// Read mux; unmapped and reserved addresses return zero, so a master that
	// probes the map sees holes as empty words rather than stale data.
	always @* begin
		next_rdata = 16'h0000;
		if (in_curve_span) begin
			if (is_curr)
				next_rdata = curr_pt[pt_idx]; // [RULE3]
			else
				next_rdata = freq_pt[pt_idx]; // [RULE2]
		end else begin
			case (addr_in)
				`DOPR_ADDR_M3_CURVE: next_rdata = m3_curve;
				`DOPR_ADDR_MODE_A:   next_rdata = mode_a;
				`DOPR_ADDR_LEVEL_A:  next_rdata = level_a;
				`DOPR_ADDR_DECEL_A:  next_rdata = decel_a;
				`DOPR_ADDR_MODE_B:   next_rdata = mode_b;
				`DOPR_ADDR_LEVEL_B:  next_rdata = level_b;
				`DOPR_ADDR_DECEL_B:  next_rdata = decel_b;
				`DOPR_ADDR_OC_SUPP:  next_rdata = oc_supp;
				`DOPR_ADDR_FM_LIMIT: next_rdata = fm_limit;
				default:             next_rdata = 16'h0000; // [RULE12]
			endcase
		end
	end

	// Writes to holes vanish without a refusal, since no register stands there
	// whose old value a refusal would protect.
	always @* begin
		next_reject = 1'b0;
		if (wr_in && hit && !ok)
			next_reject = 1'b1; // [RULE11]
	end

	// Read data is held only in the cycle after the strobe so a stale word
	// is never mistaken for a fresh answer.
	always @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			rdata_out <= 16'h0000;
		end else begin
			rdata_out <= rd_in ? next_rdata : 16'h0000;
		end
	end

	// The refusal is a one-clock pulse; a master that misses it only learns of
	// the refusal by reading the old value back.
	always @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			wr_reject_out <= 1'b0;
		end else begin
			wr_reject_out <= next_reject; // [RULE11]
		end
	end

	// The phase decodes sit in flip-flops so the drive side sees clean levels;
	// they follow a mode write by one clock.
	// Their reset levels match the decode of the reset mode.
	always @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			mode_a_accel <= 1'b1;
			mode_a_const <= 1'b1;
			mode_a_decel <= 1'b0;
		end else begin
			mode_a_accel <= (mode_a[1:0] == `DOPR_MODE_ACC_CONST) ||
			                (mode_a[1:0] == `DOPR_MODE_ALL); // [RULE4]
			mode_a_const <= (mode_a[1:0] != `DOPR_MODE_OFF); // [RULE4]
			mode_a_decel <= (mode_a[1:0] == `DOPR_MODE_ALL); // [RULE4]
		end
	end

	always @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			mode_b_accel <= 1'b1;
			mode_b_const <= 1'b1;
			mode_b_decel <= 1'b0;
		end else begin
			mode_b_accel <= (mode_b[1:0] == `DOPR_MODE_ACC_CONST) ||
			                (mode_b[1:0] == `DOPR_MODE_ALL); // [RULE5]
			mode_b_const <= (mode_b[1:0] != `DOPR_MODE_OFF); // [RULE5]
			mode_b_decel <= (mode_b[1:0] == `DOPR_MODE_ALL); // [RULE5]
		end
	end

	// Only the low bits of the selector carry meaning after a checked write.
	assign m3_curve_out     = m3_curve[1:0];
	assign mode_a_accel_out = mode_a_accel;
	assign mode_a_const_out = mode_a_const;
	assign mode_a_decel_out = mode_a_decel;
	assign mode_b_accel_out = mode_b_accel;
	assign mode_b_const_out = mode_b_const;
	assign mode_b_decel_out = mode_b_decel;
	assign level_a_out      = level_a;
	assign decel_a_out      = decel_a;
	assign level_b_out      = level_b;
	assign decel_b_out      = decel_b;
	assign oc_suppress_out  = oc_supp[0]; // [RULE9]
	assign fm_limit_out     = fm_limit;

endmodule // dopr_drive_overload_param_regs

// ---- tb/dopr_regs_assertions.sv ----
`timescale 1ns/1ps
`include "dopr_defs.vh"
module dopr_regs_assertions (
	input wire        clk_in, reset_in, wr_in, rd_in, wr_reject_out, oc_suppress_out,
	input wire        mode_a_accel_out, mode_a_const_out, mode_a_decel_out,
	input wire        mode_b_accel_out, mode_b_const_out, mode_b_decel_out,
	input wire [15:0] addr_in, wdata_in, rdata_out, decel_b_out,
	input wire [1:0]  m3_curve_out,
	input wire [47:0] curve_freq_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (reset_in);
	a_curve_sel_range: assert property (
		m3_curve_out <= 2'h2) else $error("curve select out of range");
	a_freq_pt1_write: assert property (
		wr_in && addr_in == `DOPR_ADDR_FREQ_PT1 && wdata_in <= `DOPR_FREQ_MAX
		|=> curve_freq_out[15:0] == $past(wdata_in)) else $error("freq point 1 not stored");
	a_mode_a_decode: assert property (
		(mode_a_accel_out || mode_a_decel_out) |-> mode_a_const_out
		&& (!mode_a_decel_out || mode_a_accel_out)) else $error("mode A decode illegal");
	a_mode_b_decode: assert property (
		(mode_b_accel_out || mode_b_decel_out) |-> mode_b_const_out
		&& (!mode_b_decel_out || mode_b_accel_out)) else $error("mode B decode illegal");
	a_decel_b_range: assert property (
		decel_b_out >= `DOPR_DECEL_B_MIN && decel_b_out <= `DOPR_DECEL_MAX)
		else $error("decel B out of range");
	a_oc_bad_hold: assert property (
		wr_in && addr_in == `DOPR_ADDR_OC_SUPP && wdata_in > 16'h0001
		|=> $stable(oc_suppress_out) && wr_reject_out) else $error("bad enable write taken");
	a_reject_cause: assert property (
		wr_reject_out |-> $past(wr_in)) else $error("reject without write");
	a_rsv_read_zero: assert property (
		rd_in && addr_in >= `DOPR_ADDR_RSV_FIRST && addr_in <= `DOPR_ADDR_RSV_LAST
		|=> rdata_out == 16'h0000) else $error("reserved read not zero");
endmodule // dopr_regs_assertions

bind dopr_drive_overload_param_regs dopr_regs_assertions chk_u (.clk_in(clk_in),
	.reset_in(reset_in), .wr_in(wr_in), .rd_in(rd_in), .wr_reject_out(wr_reject_out),
	.oc_suppress_out(oc_suppress_out), .mode_a_accel_out(mode_a_accel_out),
	.mode_a_const_out(mode_a_const_out), .mode_a_decel_out(mode_a_decel_out),
	.mode_b_accel_out(mode_b_accel_out), .mode_b_const_out(mode_b_const_out),
	.mode_b_decel_out(mode_b_decel_out), .addr_in(addr_in), .wdata_in(wdata_in),
	.rdata_out(rdata_out), .decel_b_out(decel_b_out), .m3_curve_out(m3_curve_out),
	.curve_freq_out(curve_freq_out));

// ---- tb/dopr_bus_master.sv ----
`timescale 1ns/1ps
module dopr_bus_master (
	input  wire        clk_in,                 // Bus clock
	input  wire [15:0] rdata_in,               // Read data
	input  wire        rej_in,                 // Write refused
	output reg  [15:0] addr_out  = 16'h0000,   // Word address
	output reg  [15:0] wdata_out = 16'h0000,   // Write data
	output reg         wr_out    = 1'b0,       // Write strobe
	output reg         rd_out    = 1'b0        // Read strobe
);
	// The refusal pulse and read data stand one cycle only, so both are taken just past that edge.
	task automatic wr_word(input logic [15:0] a, input logic [15:0] d, output logic r);
		@(posedge clk_in);
		addr_out <= a;
		wdata_out <= d;
		wr_out <= 1'b1;
		@(posedge clk_in);
		wr_out <= 1'b0;
		#1 r = rej_in;
	endtask
	task automatic rd_word(input logic [15:0] a, output logic [15:0] d);
		@(posedge clk_in);
		addr_out <= a;
		rd_out <= 1'b1;
		@(posedge clk_in);
		rd_out <= 1'b0;
		#1 d = rdata_in;
	endtask
endmodule // dopr_bus_master

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
	reg          clk_in   = 1'b0;
	reg          reset_in = 1'b1;
	wire [15:0]  addr, wdata, rdata, level_a, decel_a, level_b, decel_b, fm_limit;
	wire         wr, rd, rej, oc_supp, a_acc, a_con, a_dec, b_acc, b_con, b_dec;
	wire [1:0]   curve;
	wire [47:0]  freq, curr;
	logic [15:0] got, a;
	logic        r;
	int          miscompares = 0;
	int          n_checks = 0;
	logic [15:0] lo [15] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'hc8,
		16'ha, 16'h0, 16'hc8, 16'h1, 16'h0, 16'hc8, 16'h0};
	logic [15:0] hi [15] = '{16'h190, 16'h3e8, 16'h190, 16'h3e8, 16'h190, 16'h3e8, 16'h3,
		16'h7d0, 16'hbb8, 16'h3, 16'h7d0, 16'hbb8, 16'h1, 16'h7d0, 16'h2};
	logic [15:0] rs [15] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h1, 16'h5dc,
		16'h64, 16'h1, 16'h5dc, 16'h64, 16'h1, 16'h3e8, 16'h1};
	localparam [11:0] MODE_BITS = 12'heb0;
	always #12.5 clk_in = ~clk_in;
	dopr_bus_master m (.clk_in(clk_in), .rdata_in(rdata), .rej_in(rej), .addr_out(addr),
		.wdata_out(wdata), .wr_out(wr), .rd_out(rd));
	dopr_drive_overload_param_regs dut_u (.clk_in(clk_in), .reset_in(reset_in),
		.addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
		.wr_reject_out(rej), .m3_curve_out(curve), .curve_freq_out(freq),
		.curve_curr_out(curr), .mode_a_accel_out(a_acc), .mode_a_const_out(a_con),
		.mode_a_decel_out(a_dec), .mode_b_accel_out(b_acc), .mode_b_const_out(b_con),
		.mode_b_decel_out(b_dec), .level_a_out(level_a), .decel_a_out(decel_a),
		.level_b_out(level_b), .decel_b_out(decel_b), .oc_suppress_out(oc_supp),
		.fm_limit_out(fm_limit));
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// One write, its refusal flag, then a read back of the same word.
	task automatic step(input logic [15:0] ad, input logic [15:0] v, input logic rj,
		input logic [15:0] exp);
		m.wr_word(ad, v, r);
		chk({15'h0, r}, {15'h0, rj});
		m.rd_word(ad, got);
		chk(got, exp);
	endtask
	task automatic finish_test;
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	initial begin
		#100000;
		miscompares++;
		finish_test;
	end
	initial begin
		repeat (5) @(posedge clk_in);
		reset_in <= 1'b0;
		for (int i = 0; i < 15; i++) begin
			a = (i == 14) ? 16'h330d : 16'h1310 + i[15:0];
			m.rd_word(a, got);
			chk(got, rs[i]);
			step(a, hi[i], 1'b0, hi[i]);
			step(a, hi[i] + 16'h1, 1'b1, hi[i]);
			if (lo[i] != 16'h0) step(a, lo[i] - 16'h1, 1'b1, hi[i]);
			step(a, lo[i], 1'b0, lo[i]);
		end
		chk({level_a, decel_a, level_b, decel_b}, 64'h00c8_000a_00c8_0001);
		chk({fm_limit[14:0], oc_supp}, {15'h00c8, 1'b0});
		step(16'h1312, 16'h0123, 1'b0, 16'h0123);
		step(16'h1315, 16'h0321, 1'b0, 16'h0321);
		chk({freq[31:16], curr[47:32]}, 32'h0123_0321);
		for (int k = 0; k < 4; k++) begin
			step(16'h1316, k[15:0], 1'b0, k[15:0]);
			step(16'h1319, k[15:0], 1'b0, k[15:0]);
			chk({a_acc, a_con, a_dec, b_acc, b_con, b_dec}, {2{MODE_BITS[3 * k +: 3]}});
		end
		step(16'h330e, 16'h1234, 1'b0, 16'h0000);
		m.rd_word(16'h3506, got);
		chk(got, 16'h0000);
		chk({14'h0, curve}, 16'h0000);
		finish_test;
	end
endmodule // tb_top
